// file: test/tb_utopia_slave_cell_transmit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) \
  begin \
    checks = checks + 1; \
    if ((e) !== (s)) \
    begin \
      fails = fails + 1; \
      $display("mismatch %s expected %h seen %h", nm, e, s); \
    end \
  end
module tb_utopia_slave_cell_transmit;
  import utx_pkg::*;
  // ------
  // Bench
  // ------
  logic       core_clk_in;
  logic       nrst_in;
  logic       cell_port_select_in;
  logic [4:0] own_addr_in;
  logic       tx_cell_clock_in;
  logic       tx_master_enable_n_in;
  logic [4:0] tx_slave_select_addr_in;
  logic       cell_load_valid_in;
  logic [7:0] cell_load_byte_in;
  logic       cell_load_ready_out;
  logic       tx_cell_ready_out;
  logic       tx_cell_ready_oe_n_out;
  logic       tx_start_of_cell_out;
  logic       tx_start_of_cell_oe_n_out;
  logic [7:0] tx_byte_bus_out;
  logic       tx_byte_bus_oe_n_out;
  logic       serial_pins_active_out;
  logic       seen_stb;
  logic [8:0] seen_unit;
  logic [8:0] note;
  logic [4:0] other_addr;
  logic [8:0] note_q[$];
  int         fails = 0;
  int         checks = 0;
  utx_slave_tx DUT
  (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .cell_port_select_in(cell_port_select_in), .own_addr_in(own_addr_in),
    .tx_cell_clock_in(tx_cell_clock_in),
    .tx_master_enable_n_in(tx_master_enable_n_in),
    .tx_slave_select_addr_in(tx_slave_select_addr_in),
    .cell_load_valid_in(cell_load_valid_in),
    .cell_load_byte_in(cell_load_byte_in),
    .cell_load_ready_out(cell_load_ready_out),
    .tx_cell_ready_out(tx_cell_ready_out),
    .tx_cell_ready_oe_n_out(tx_cell_ready_oe_n_out),
    .tx_start_of_cell_out(tx_start_of_cell_out),
    .tx_start_of_cell_oe_n_out(tx_start_of_cell_oe_n_out),
    .tx_byte_bus_out(tx_byte_bus_out),
    .tx_byte_bus_oe_n_out(tx_byte_bus_oe_n_out),
    .serial_pins_active_out(serial_pins_active_out)
  );
  utx_master_model M
  (
    .tx_cell_clock_out(tx_cell_clock_in),
    .tx_master_enable_n_out(tx_master_enable_n_in),
    .tx_slave_select_addr_out(tx_slave_select_addr_in),
    .tx_byte_bus_in(tx_byte_bus_out),
    .tx_byte_bus_oe_n_in(tx_byte_bus_oe_n_out),
    .tx_start_of_cell_in(tx_start_of_cell_out),
    .tx_start_of_cell_oe_n_in(tx_start_of_cell_oe_n_out),
    .seen_stb_out(seen_stb), .seen_unit_out(seen_unit)
  );
  task automatic results();
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // One write past the end, which must be ignored
  task automatic load_cell(input logic keep);
    for (int i = 0; i <= int'(CELL_LEN); i++)
    begin
      settle(1);
      cell_load_valid_in = 1'b1;
      cell_load_byte_in  = 8'($urandom);
      if (keep && i < int'(CELL_LEN))
        note_q.push_back({i == 0, cell_load_byte_in});
    end
    settle(1);
    cell_load_valid_in = 1'b0;
    `CHK("load_ready", 1'b0, cell_load_ready_out)
  endtask
  task automatic poll(input logic [4:0] addr, input logic oe_n_exp);
    repeat (3) M.link_edge(1'b1, addr, 1'b0);
    settle(6);
    `CHK("clav_oe_n", oe_n_exp, tx_cell_ready_oe_n_out)
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    #200000;
    fails = fails + 1;
    results();
  end
  always @(posedge seen_stb)
  begin
    note = (note_q.size() == 0) ? ~seen_unit : note_q.pop_front();
    `CHK("soc", note[8], seen_unit[8])
    `CHK("byte", note[7:0], seen_unit[7:0])
  end
  initial
  begin
    void'($urandom(32'h2285));
    nrst_in             = 1'b0;
    cell_port_select_in = 1'b1;
    own_addr_in         = 5'($urandom % 31);
    cell_load_valid_in  = 1'b0;
    cell_load_byte_in   = 8'h00;
    other_addr = (own_addr_in == 5'h1E) ? 5'h00 : own_addr_in + 5'h01;
    settle(12);
    nrst_in = 1'b1;
    settle(4);
    `CHK("serial", 1'b0, serial_pins_active_out)
    for (int r = 0; r < 2; r++)
    begin
      `CHK("clav", 1'b0, tx_cell_ready_out)
      load_cell(1'b1);
      settle(2);
      // Cell ready only moves on a link edge, so poll first
      poll(other_addr, 1'b1);
      `CHK("clav", 1'b1, tx_cell_ready_out)
      poll(own_addr_in, 1'b0);
      M.send_cell(own_addr_in, r[0]);
      settle(6);
      `CHK("load_ready", 1'b1, cell_load_ready_out)
    end
    `CHK("left", 0, note_q.size())
    // Full store but strap low: the link must stay silent
    load_cell(1'b0);
    cell_port_select_in = 1'b0;
    repeat (4) M.link_edge(1'b0, own_addr_in, 1'b0);
    // Pin lsb low: the tie-off must still present it as high
    M.link_edge(1'b0, {own_addr_in[4:1], 1'b0}, 1'b0);
    settle(6);
    `CHK("addr_lsb", 1'b1, DUT.sel_addr[0])
    `CHK("serial", 1'b1, serial_pins_active_out)
    `CHK("clav_oe_n", 1'b1, tx_cell_ready_oe_n_out)
    `CHK("bus_oe_n", 1'b1, tx_byte_bus_oe_n_out)
    `CHK("soc_oe_n", 1'b1, tx_start_of_cell_oe_n_out)
    `CHK("soc_out", 1'b0, tx_start_of_cell_out)
    results();
  end
endmodule
`default_nettype wire

// file: test/utx_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module utx_master_model
  import utx_pkg::*;
(
  output logic            tx_cell_clock_out,
  output logic            tx_master_enable_n_out,
  output logic [4:0]      tx_slave_select_addr_out,
  input  wire logic [7:0] tx_byte_bus_in,
  input  wire logic       tx_byte_bus_oe_n_in,
  input  wire logic       tx_start_of_cell_in,
  input  wire logic       tx_start_of_cell_oe_n_in,
  output logic            seen_stb_out,
  output logic [8:0]      seen_unit_out
);
  // ------
  // Link master
  // ------
  logic [8:0] last_reg;
  logic [8:0] line_now;
  // Floating lines read as the inverse of their last level
  assign line_now[8] = tx_start_of_cell_oe_n_in ? ~last_reg[8]
                                                : tx_start_of_cell_in;
  assign line_now[7:0] = tx_byte_bus_oe_n_in ? ~last_reg[7:0]
                                             : tx_byte_bus_in;
  initial
  begin
    tx_cell_clock_out        = 1'b0;
    tx_master_enable_n_out   = 1'b1;
    tx_slave_select_addr_out = NULL_ADDR;
    seen_stb_out             = 1'b0;
    seen_unit_out            = 9'h000;
    last_reg                 = 9'h000;
  end
  // Clock runs only in here, so it stands still between frames
  task automatic link_edge(input logic enb_n, input logic [4:0] addr,
                           input logic take);
    tx_master_enable_n_out   = enb_n;
    tx_slave_select_addr_out = addr;
    #43 tx_cell_clock_out = 1'b1;
    if (take)
    begin
      seen_unit_out = line_now;
      seen_stb_out  = 1'b1;
    end
    last_reg = line_now;
    #37 tx_cell_clock_out = 1'b0;
    seen_stb_out = 1'b0;
  endtask
  // Byte taken on each edge after an edge with enable low
  task automatic send_cell(input logic [4:0] addr, input logic stall);
    int   got;
    int   e;
    logic prev_n;
    logic hold_n;
    got    = 0;
    e      = 0;
    prev_n = 1'b1;
    while (got < int'(CELL_LEN))
    begin
      hold_n = stall && (e % 7 == 3) && (got < 50);
      link_edge(hold_n, addr, !prev_n);
      got    = got + int'(!prev_n);
      prev_n = hold_n;
      e      = e + 1;
    end
    tx_master_enable_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verilog/utx_pkg.sv
`default_nettype none
package utx_pkg;
  // ---------------------------------------------------------------
  // Link geometry
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned CELL_LEN    = 53;
  localparam int unsigned CNT_W       = 6;
  localparam logic [4:0]  NULL_ADDR   = 5'h1F;
  localparam logic [4:0]  OWN_ADDR_RST = 5'h00;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [5:0]  CNT_RST     = 6'h00;
  localparam logic [5:0]  CELL_LAST   = 6'(CELL_LEN - 1);

  typedef enum logic [1:0] {UTX_IDLE, UTX_ARMED, UTX_SEND} utx_state_type;
endpackage
`default_nettype wire

// file: verilog/utx_slave_tx.sv
// Contract
// - Cell ready low until whole cell held
// - Enable asserted, next cycle first byte and start
// - Start marks first byte, launched on rising edge
// - Strap high makes shared pins address inputs
// - Strap low ties off transmit link pins
// - Strap low ties off address lsb
// - One byte per link clock with enable low on bus
`timescale 1ns/1ps
`default_nettype none
module utx_slave_tx
  import utx_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 cell_port_select_in,
  input  wire logic [4:0]           own_addr_in,
  input  wire logic                 tx_cell_clock_in,
  input  wire logic                 tx_master_enable_n_in,
  input  wire logic [4:0]           tx_slave_select_addr_in,
  input  wire logic                 cell_load_valid_in,
  input  wire logic [7:0]           cell_load_byte_in,
  output logic                      cell_load_ready_out,
  output logic                      tx_cell_ready_out,
  output logic                      tx_cell_ready_oe_n_out,
  output logic                      tx_start_of_cell_out,
  output logic                      tx_start_of_cell_oe_n_out,
  output logic [7:0]                tx_byte_bus_out,
  output logic                      tx_byte_bus_oe_n_out,
  output logic                      serial_pins_active_out
);
  import utx_pkg::*;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic       clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic       enb_s1_reg, enb_s2_reg;
  logic [4:0] adr_s1_reg, adr_s2_reg;
  logic       sel_s1_reg, sel_s2_reg;

  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      enb_s1_reg <= 1'b1;
      enb_s2_reg <= 1'b1;
      adr_s1_reg <= NULL_ADDR;
      adr_s2_reg <= NULL_ADDR;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end
    else
    begin
      clk_s1_reg <= tx_cell_clock_in;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      enb_s1_reg <= tx_master_enable_n_in;
      enb_s2_reg <= enb_s1_reg;
      adr_s1_reg <= tx_slave_select_addr_in;
      adr_s2_reg <= adr_s1_reg;
      sel_s1_reg <= cell_port_select_in;
      sel_s2_reg <= sel_s1_reg;
    end

  // Tie-off: strap low forces idle levels onto link inputs
  logic       en_port;
  logic       link_rise;
  logic       enb_n;
  logic [4:0] sel_addr;
  assign en_port   = sel_s2_reg;
  assign link_rise = en_port && clk_s2_reg && !clk_s3_reg;
  assign enb_n     = en_port ? enb_s2_reg : 1'b1;
  assign sel_addr  = en_port ? adr_s2_reg
                             : {NULL_ADDR[4:1], 1'b1};

  // ---------------------------------------------------------------
  // Cell store, loaded from the core side
  // ---------------------------------------------------------------
  // One cell only: keeps area small, core must wait for drain
  logic [7:0]    cell_mem [CELL_LEN];
  logic [5:0]    wr_cnt_reg;
  logic [5:0]    rd_cnt_reg;
  logic          full_reg;
  utx_state_type state_reg;
  logic          addressed_reg;
  logic          sent_last;

  assign sent_last = link_rise && state_reg == UTX_SEND
                     && rd_cnt_reg == CELL_LAST && !enb_n;

  always_ff @(posedge core_clk_in)
    if (cell_load_valid_in && !full_reg)
      cell_mem[wr_cnt_reg] <= cell_load_byte_in;

  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      wr_cnt_reg          <= CNT_RST;
      full_reg            <= 1'b0;
      cell_load_ready_out <= 1'b1;
    end
    else if (sent_last)
    begin
      wr_cnt_reg          <= CNT_RST;
      full_reg            <= 1'b0;
      cell_load_ready_out <= 1'b1;
    end
    else if (cell_load_valid_in && !full_reg)
    begin
      wr_cnt_reg          <= wr_cnt_reg + 6'h01;
      full_reg            <= (wr_cnt_reg == CELL_LAST);
      // Own flop so the core sees a clean registered level
      cell_load_ready_out <= !(wr_cnt_reg == CELL_LAST);
    end

  // ---------------------------------------------------------------
  // Link side state machine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
      addressed_reg <= 1'b0;
    else if (link_rise)
      addressed_reg <= (sel_addr == own_addr_in) && en_port;

  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      state_reg  <= UTX_IDLE;
      rd_cnt_reg <= CNT_RST;
    end
    else if (!en_port)
    begin
      state_reg  <= UTX_IDLE;
      rd_cnt_reg <= CNT_RST;
    end
    else if (link_rise)
      case (state_reg)
        UTX_IDLE:
          if (full_reg && !enb_n && sel_addr == own_addr_in)
          begin
            state_reg  <= UTX_SEND;
            rd_cnt_reg <= CNT_RST;
          end
        UTX_SEND:
          if (!enb_n)
          begin
            if (rd_cnt_reg == CELL_LAST)
              state_reg <= UTX_IDLE;
            else
              rd_cnt_reg <= rd_cnt_reg + 6'h01;
          end
        default:
          state_reg <= UTX_IDLE;
      endcase

  // ---------------------------------------------------------------
  // Output launch on the link rising edge
  // ---------------------------------------------------------------
  // Enable pause holds the byte; master may stall mid cell
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      tx_byte_bus_out           <= BYTE_RST;
      tx_start_of_cell_out      <= 1'b0;
      tx_cell_ready_out         <= 1'b0;
      tx_cell_ready_oe_n_out    <= 1'b1;
      tx_start_of_cell_oe_n_out <= 1'b1;
      tx_byte_bus_oe_n_out      <= 1'b1;
      serial_pins_active_out    <= 1'b1;
    end
    else
    begin
      serial_pins_active_out <= !en_port;
      if (!en_port)
      begin
        tx_cell_ready_out         <= 1'b0;
        tx_start_of_cell_out      <= 1'b0;
        tx_byte_bus_out           <= BYTE_RST;
        tx_cell_ready_oe_n_out    <= 1'b1;
        tx_start_of_cell_oe_n_out <= 1'b1;
        tx_byte_bus_oe_n_out      <= 1'b1;
      end
      else if (link_rise)
      begin
        tx_cell_ready_out      <= full_reg && !sent_last;
        tx_cell_ready_oe_n_out <= !(sel_addr == own_addr_in);
        tx_start_of_cell_oe_n_out <= !addressed_reg && enb_n;
        tx_byte_bus_oe_n_out      <= !addressed_reg && enb_n;
        if (state_reg == UTX_IDLE && full_reg && !enb_n
            && sel_addr == own_addr_in)
        begin
          tx_byte_bus_out           <= cell_mem[CNT_RST];
          tx_start_of_cell_out      <= 1'b1;
          tx_start_of_cell_oe_n_out <= 1'b0;
          tx_byte_bus_oe_n_out      <= 1'b0;
        end
        else if (state_reg == UTX_SEND && !enb_n)
        begin
          tx_start_of_cell_out <= 1'b0;
          if (rd_cnt_reg != CELL_LAST)
            tx_byte_bus_out <= cell_mem[rd_cnt_reg + 6'h01];
        end
        else
          tx_start_of_cell_out <= 1'b0;
      end
    end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_start_req;
    link_rise && state_reg == UTX_IDLE && full_reg && !enb_n
      && sel_addr == own_addr_in;
  endsequence

  property p_start_follows;
    @(posedge core_clk_in) disable iff (!nrst_in)
    s_start_req |=> tx_start_of_cell_out && !tx_byte_bus_oe_n_out;
  endproperty
  a_start_follows: assert property (p_start_follows)
    else $error("start of cell missing after enable");

  property p_soc_first_byte;
    @(posedge core_clk_in) disable iff (!nrst_in)
    $rose(tx_start_of_cell_out) |-> state_reg == UTX_SEND
      && rd_cnt_reg == CNT_RST;
  endproperty
  a_soc_first_byte: assert property (p_soc_first_byte)
    else $error("start of cell not on first byte");

  property p_ready_empty;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (link_rise && !full_reg) |=> !tx_cell_ready_out;
  endproperty
  a_ready_empty: assert property (p_ready_empty)
    else $error("cell ready without full cell");

  property p_tieoff;
    @(posedge core_clk_in) disable iff (!nrst_in)
    !en_port |=> tx_cell_ready_oe_n_out && tx_byte_bus_oe_n_out
      && !tx_start_of_cell_out && serial_pins_active_out;
  endproperty
  a_tieoff: assert property (p_tieoff)
    else $error("link pins not tied off");

  property p_lsb_tie;
    @(posedge core_clk_in) disable iff (!nrst_in)
    !en_port |-> sel_addr[0];
  endproperty
  a_lsb_tie: assert property (p_lsb_tie)
    else $error("address lsb not tied off");

  property p_other_addr;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (link_rise && en_port && sel_addr != own_addr_in)
      |=> tx_cell_ready_oe_n_out;
  endproperty
  a_other_addr: assert property (p_other_addr)
    else $error("ready driven for foreign address");

  property p_byte_step;
    @(posedge core_clk_in) disable iff (!nrst_in)
    (link_rise && state_reg == UTX_SEND && !enb_n
      && rd_cnt_reg != CELL_LAST) |=> rd_cnt_reg == $past(rd_cnt_reg) + 6'h01;
  endproperty
  a_byte_step: assert property (p_byte_step)
    else $error("byte counter did not advance");

  property p_mode_out;
    @(posedge core_clk_in) disable iff (!nrst_in)
    en_port |=> !serial_pins_active_out;
  endproperty
  a_mode_out: assert property (p_mode_out)
    else $error("serial pins active with strap high");
endmodule
`default_nettype wire
